/* File: rtl/mch_pkg.sv */
// Constants, types and opcodes shared by the command handshake block.
// Assumes one 100 MHz core clock and an asynchronous active-low reset.
package mch_pkg;

    // =========================================================
    // Clock and reset sequencing
    // =========================================================
    localparam int         CLK_MHZ     = 100;
    localparam int         RST_CYCLES  = 5;
    localparam logic [2:0] RST_LAST    = 3'(RST_CYCLES - 1);

    // =========================================================
    // Execution times in core clock cycles (plain defaults)
    // =========================================================
    localparam logic [11:0] EXEC_CYC_BASIC = 12'h010;
    localparam logic [11:0] EXEC_CYC_TRANS = 12'h100;
    localparam logic [11:0] EXEC_CYC_CONV  = 12'h020;
    localparam logic [11:0] EXEC_CYC_UNDEF = 12'h004;

    // =========================================================
    // Command byte fields and opcodes
    // =========================================================
    localparam int CMD_SVC_BIT    = 7;
    localparam int CMD_SINGLE_BIT = 6;
    localparam int CMD_FIXED_BIT  = 5;
    localparam int CMD_OP_MSB     = 4;

    localparam logic [4:0] OP_TRIG_OPCODE_A        = 5'h02;
    localparam logic [4:0] OP_TRIG_OPCODE_B        = 5'h03;
    localparam logic [4:0] OP_TRIG_OPCODE_C        = 5'h04;
    localparam logic [4:0] OP_ARC_TRIG_A           = 5'h05;
    localparam logic [4:0] OP_ARC_TRIG_B           = 5'h06;
    localparam logic [4:0] OP_ARC_TRIG_C           = 5'h07;
    localparam logic [4:0] OP_DECIMAL_INVERSE_POWER = 5'h08;
    localparam logic [4:0] OP_NATURAL_LOGARITHM    = 5'h09;
    localparam logic [4:0] OP_NATURAL_POWER_FN     = 5'h0a;
    localparam logic [4:0] OP_INT32_TO_REAL        = 5'h1c;
    localparam logic [4:0] OP_INT16_TO_REAL        = 5'h1d;

    // =========================================================
    // Status byte layout
    // =========================================================
    localparam int STAT_BUSY_BIT    = 7;
    localparam int STAT_ILLEGAL_BIT = 0;

    // =========================================================
    // Byte stack
    // =========================================================
    localparam int         STACK_DEPTH = 16;
    localparam logic [3:0] SP_RESET    = 4'h0;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_DONE  = 3'b011
    } mch_state_t;

    typedef enum logic [2:0] {
        CL_BASIC = 3'b000,
        CL_TRIG  = 3'b001,
        CL_ARC   = 3'b010,
        CL_LOGEX = 3'b011,
        CL_CONV  = 3'b100,
        CL_UNDEF = 3'b101
    } mch_class_t;

    typedef struct packed {
        logic       svc;
        logic       single;
        logic       fixed;
        logic [4:0] op;
    } mch_cmd_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       sel;
        logic       service_ack_in_n;
        logic       end_ack_n_n;
        logic [7:0] data;
    } mch_pins_t;

endpackage

/* File: rtl/mch_sync.sv */
// Two-flop synchronisers for every host pin of the handshake block.
// Assumes pins are asynchronous to core_clk; the first stage feeds only the second.
module mch_sync (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire mch_pkg::mch_pins_t pins_in,
    output mch_pkg::mch_pins_t     pins_out
);
    import mch_pkg::*;

    localparam int W = $bits(mch_pins_t);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    // =========================================================
    // Per bit double flop; strobes idle high after reset
    // =========================================================
    for (genvar i = 0; i < W; i++) begin : g_bit
        localparam logic INIT = (i >= 8 && i != 10) ? 1'b1 : 1'b0;
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                stage1[i] <= INIT;
                stage2[i] <= INIT;
            end else begin
                stage1[i] <= pins_in[i];
                stage2[i] <= stage1[i];
            end
        end
    end

    assign pins_out = mch_pins_t'(stage2);

endmodule // mch_sync

/* File: rtl/mch_decode.sv */
// Command byte decoder: field split, opcode class and illegal combinations.
// Assumes a registered command byte on input; output is purely combinational.
module mch_decode (
    input  wire mch_pkg::mch_cmd_t cmd,
    output mch_pkg::mch_class_t    cls,
    output logic                   illegal,
    output logic [11:0]            exec_cycles
);
    import mch_pkg::*;

    // =========================================================
    // Opcode class from bits 0-4 and the format bits
    // =========================================================
    always_comb begin
        illegal = !cmd.fixed && cmd.single;
        cls     = CL_BASIC;
        if (!cmd.fixed) begin
            case (cmd.op)
                OP_TRIG_OPCODE_A,
                OP_TRIG_OPCODE_B,
                OP_TRIG_OPCODE_C:         cls = CL_TRIG;
                OP_ARC_TRIG_A,
                OP_ARC_TRIG_B,
                OP_ARC_TRIG_C:            cls = CL_ARC;
                OP_DECIMAL_INVERSE_POWER,
                OP_NATURAL_LOGARITHM,
                OP_NATURAL_POWER_FN:      cls = CL_LOGEX;
                OP_INT32_TO_REAL,
                OP_INT16_TO_REAL:         cls = CL_CONV;
                default:                  cls = CL_BASIC;
            endcase
        end
        if (illegal) begin
            cls = CL_UNDEF;
        end
    end

    // Execution time per class; fixed point precision picks basic timing
    always_comb begin
        case (cls)
            CL_TRIG, CL_ARC, CL_LOGEX: exec_cycles = EXEC_CYC_TRANS;
            CL_CONV:                   exec_cycles = EXEC_CYC_CONV;
            CL_UNDEF:                  exec_cycles = EXEC_CYC_UNDEF;
            default:                   exec_cycles = EXEC_CYC_BASIC;
        endcase
    end

endmodule // mch_decode

/* File: rtl/mch_core.sv */
// Command interpreter and host handshake of a stack arithmetic unit.
// Assumes an 8-bit host bus with chip select, strobes and a select line,
// all asynchronous to core_clk; the data bus wire is resolved outside.

module mch_core (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        chip_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        register_select,
    input  wire logic [7:0]  host_data_in,
    output logic [7:0]       host_data_out,
    output logic             host_data_oe,
    output logic             ready,
    input  wire logic        service_ack_in,
    output logic             service_request_out,
    input  wire logic        end_ack_n,
    output logic             end_of_exec_n,
    output mch_pkg::mch_cmd_t cmd_current,
    output mch_pkg::mch_class_t cmd_class
);
    import mch_pkg::*;

    // =========================================================
    // Declarations
    // =========================================================
    mch_pins_t   pins_raw;
    mch_pins_t   pins;
    mch_pins_t   pins_q;
    mch_state_t  state;
    mch_cmd_t    cmd;
    mch_class_t  cls;
    logic        illegal;
    logic        illegal_seen;
    logic [11:0] exec_cycles;
    logic [11:0] exec_cnt;
    logic [2:0]  rst_cnt;
    logic [3:0]  sp;
    logic [7:0]  stack_mem [STACK_DEPTH];
    logic [7:0]  status_byte;
    logic        busy;
    logic        acc_now;
    logic        acc_q;
    logic        acc_start;
    logic        wr_end;
    logic        rd_end;
    logic        cmd_wr_evt;
    logic        push_evt;
    logic        pop_evt;
    logic        done;

    // =========================================================
    // Pin synchronisation and command decode
    // =========================================================
    assign pins_raw = '{cs_n:    chip_select_n,
                        rd_n:    read_strobe_n,
                        wr_n:    write_strobe_n,
                        sel:     register_select,
                        service_ack_in_n: service_ack_in,
                        end_ack_n_n:  end_ack_n,
                        data:    host_data_in};

    mch_sync u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pins_in  (pins_raw),
        .pins_out (pins)
    );

    mch_decode u_decode (
        .cmd         (cmd),
        .cls         (cls),
        .illegal     (illegal),
        .exec_cycles (exec_cycles)
    );

    // Previous synchronised sample for strobe edges and held data
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pins_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 1'b0,
                        service_ack_in_n: 1'b1, end_ack_n_n: 1'b1, data: 8'h00};
            acc_q  <= 1'b0;
        end else begin
            pins_q <= pins;
            acc_q  <= acc_now;
        end
    end

    // =========================================================
    // Access decode
    // =========================================================
    // Trailing strobe edges while selected, split by register select
    assign acc_now    = !pins.cs_n && (!pins.rd_n || !pins.wr_n);
    assign acc_start  = acc_now && !acc_q;
    assign wr_end     = pins.wr_n && !pins_q.wr_n && !pins_q.cs_n;
    assign rd_end     = pins.rd_n && !pins_q.rd_n && !pins_q.cs_n;
    assign busy       = (state != ST_IDLE);
    assign cmd_wr_evt = wr_end && pins_q.sel && (state == ST_IDLE);
    assign push_evt   = wr_end && !pins_q.sel && (state == ST_IDLE);
    assign pop_evt    = rd_end && !pins_q.sel && (state == ST_IDLE);
    assign done       = (state == ST_DONE);

    // =========================================================
    // Sequencer: reset wait, idle, execute, done
    // =========================================================
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_RESET;
            rst_cnt  <= 3'h0;
            exec_cnt <= 12'h000;
        end else begin
            case (state)
                ST_RESET: begin
                    rst_cnt <= rst_cnt + 3'h1;
                    if (rst_cnt == RST_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (cmd_wr_evt) begin
                        state    <= ST_EXEC;
                        exec_cnt <= 12'h000;
                    end
                end
                ST_EXEC: begin
                    exec_cnt <= exec_cnt + 12'h001;
                    if (exec_cnt >= exec_cycles - 12'h001) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Command register keeps its contents through reset
    always_ff @(posedge core_clk) begin
        if (cmd_wr_evt) begin
            cmd <= mch_cmd_t'(pins_q.data);
        end
    end

    // =========================================================
    // Data stack; contents survive reset
    // =========================================================
    always_ff @(posedge core_clk) begin
        if (push_evt) begin
            stack_mem[sp] <= pins_q.data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sp <= SP_RESET;
        end else if (push_evt) begin
            sp <= sp + 4'h1;
        end else if (pop_evt) begin
            sp <= sp - 4'h1;
        end
    end

    // =========================================================
    // Host read path
    // =========================================================
    // Illegal flag for status; reset clears it, a new command restarts it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            illegal_seen <= 1'b0;
        end else if (done) begin
            illegal_seen <= illegal;
        end else if (cmd_wr_evt) begin
            illegal_seen <= 1'b0;
        end
    end

    // Busy drops in the completion cycle so the registered byte is idle when ready rises
    always_comb begin
        status_byte                   = 8'h00;
        status_byte[STAT_BUSY_BIT]    = busy && !done;
        status_byte[STAT_ILLEGAL_BIT] = illegal_seen;
    end

    // Read data register tracks status or stack top
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            host_data_out <= 8'h00;
        end else if (pins.sel) begin
            host_data_out <= status_byte;
        end else begin
            host_data_out <= stack_mem[sp - 4'h1];
        end
    end

    // Bus drive follows the pins directly so it never outlives the strobe
    assign host_data_oe = !chip_select_n && !read_strobe_n;

    // Stall any access while a command or the reset wait is running
    assign ready = !(busy && acc_now);

    // =========================================================
    // Service request and end of execution
    // =========================================================
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            service_request_out <= 1'b0;
        end else if (done && cmd.svc) begin
            service_request_out <= 1'b1;
        end else if (!pins.service_ack_in_n || cmd_wr_evt) begin
            service_request_out <= 1'b0;
        end
    end

    // Completion wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            end_of_exec_n <= 1'b1;
        end else if (done) begin
            end_of_exec_n <= 1'b0;
        end else if (!pins.end_ack_n_n || acc_start) begin
            end_of_exec_n <= 1'b1;
        end
    end

    assign cmd_current = cmd;
    assign cmd_class   = cls;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_cmd_taken;
        cmd_wr_evt ##1 (state == ST_EXEC);
    endsequence

    sequence s_done_svc;
        done && cmd.svc;
    endsequence

    a_svc_set_done: assert property (s_done_svc |=> service_request_out)
        else $error("service request not raised after completion");

    a_svc_hold_high: assert property (service_request_out && pins.service_ack_in_n && !cmd_wr_evt
        |=> service_request_out)
        else $error("service request dropped without acknowledge");

    a_svc_ack_clear: assert property (service_request_out && !pins.service_ack_in_n && !done
        |=> !service_request_out)
        else $error("service request not cleared by acknowledge");

    a_svc_cmd_clear: assert property (cmd_wr_evt |=> !service_request_out)
        else $error("service request survived a new command");

    a_svc_stay_low: assert property (done && !cmd.svc && !service_request_out
        |=> !service_request_out)
        else $error("service request raised for command without request");

    a_ready_stall: assert property ((state == ST_EXEC) && acc_now |-> !ready)
        else $error("ready high during execution with access");

    a_ready_idle: assert property ((state == ST_IDLE) |-> ready)
        else $error("ready low while idle");

    a_bus_drive: assert property (host_data_oe |-> !chip_select_n && !read_strobe_n)
        else $error("data bus driven outside select and read");

    a_cmd_start: assert property (cmd_wr_evt |-> s_cmd_taken)
        else $error("command did not start on next clock");

    a_end_assert: assert property (done |=> !end_of_exec_n)
        else $error("end of execution not asserted on completion");

    a_end_ack_clear: assert property (!end_of_exec_n && !pins.end_ack_n_n && !done
        |=> end_of_exec_n)
        else $error("end of execution not cleared by acknowledge");

    a_reset_wait: assert property ((state == ST_RESET) && (rst_cnt == 3'h1)
        |-> (state == ST_RESET) [*4] ##1 (state == ST_IDLE))
        else $error("reset wait not five cycles");

    a_trans_class: assert property (!cmd.fixed && !cmd.single && (cmd.op == OP_NATURAL_LOGARITHM)
        |-> cls == CL_LOGEX)
        else $error("logarithm opcode misdecoded");

endmodule // mch_core

/* File: verification/mch_host_model.sv */
// Host side model: drives chip select, strobes, select and the data bus.
// Assumes the core synchronises every pin and stalls via ready.
module mch_host_model (
    input  wire logic       core_clk,
    output logic            chip_select_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic            register_select,
    output logic [7:0]      host_data_in,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe,
    input  wire logic       ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] drive;
    logic       drv_en;
    logic [7:0] last;

    // =========================================================
    // Bus wire: host, device, or a changing pattern when free
    // =========================================================
    assign host_data_in = drv_en ? drive : (host_data_oe ? host_data_out : ~last);

    always @(posedge core_clk) last <= host_data_in;

    initial begin
        chip_select_n   = 1'b1;
        read_strobe_n   = 1'b1;
        write_strobe_n  = 1'b1;
        register_select = 1'b0;
        drive           = 8'h00;
        drv_en          = 1'b0;
        last            = 8'h00;
    end

    // One access; strobe held until ready, then released with gaps
    task automatic access(input logic sel, input logic wr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic stalled);
        int n;
        n = 0;
        stalled = 1'b0;
        @(posedge core_clk);
        chip_select_n   <= 1'b0;
        register_select <= sel;
        drive           <= wdata;
        drv_en          <= wr;
        write_strobe_n  <= ~wr;
        read_strobe_n   <= wr;
        do begin
            @(negedge core_clk);
            n++;
            if (ready !== 1'b1) stalled = 1'b1;
        end while ((n < 5 || ready !== 1'b1) && n < 1000);
        rdata = host_data_oe ? host_data_out : 8'hxx;
        @(posedge core_clk);
        write_strobe_n <= 1'b1;
        read_strobe_n  <= 1'b1;
        repeat (3) @(posedge core_clk);
        chip_select_n <= 1'b1;
        drv_en        <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule // mch_host_model

/* File: verification/test_math_unit_command_handshake.sv */
// Self-checking bench for the command handshake core.
// Assumes mch_pkg and mch_core compiled first; bus pins come from the model, service_ack_in and end_ack_n from the bench.
module test_math_unit_command_handshake;
    import mch_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       chip_select_n, read_strobe_n, write_strobe_n, register_select;
    logic [7:0] host_data_in, host_data_out;
    logic       host_data_oe, ready, end_of_exec_n, service_request_out;
    logic       service_ack_in = 1'b1;
    logic       end_ack_n = 1'b1;
    mch_cmd_t   cmd_current;
    mch_class_t cmd_class;
    int         fail_count = 0;
    int         comparisons = 0;
    int         cycles = 0;
    logic [7:0] rdv;
    logic       stv;

    logic [7:0] cmds [12] = '{8'h82, 8'h03, 8'h84, 8'h85, 8'h06, 8'h87,
                              8'h08, 8'h89, 8'h0a, 8'h9c, 8'h1d, 8'hec};
    mch_class_t cls [12] = '{CL_TRIG, CL_TRIG, CL_TRIG, CL_ARC, CL_ARC, CL_ARC,
                             CL_LOGEX, CL_LOGEX, CL_LOGEX, CL_CONV, CL_CONV, CL_BASIC};

    always #5 core_clk = ~core_clk;

    mch_core i_dut (
        .core_clk            (core_clk),
        .rstn                (rstn),
        .chip_select_n       (chip_select_n),
        .read_strobe_n       (read_strobe_n),
        .write_strobe_n      (write_strobe_n),
        .register_select     (register_select),
        .host_data_in        (host_data_in),
        .host_data_out       (host_data_out),
        .host_data_oe        (host_data_oe),
        .ready               (ready),
        .service_ack_in      (service_ack_in),
        .service_request_out (service_request_out),
        .end_ack_n           (end_ack_n),
        .end_of_exec_n       (end_of_exec_n),
        .cmd_current         (cmd_current),
        .cmd_class           (cmd_class)
    );

    mch_host_model i_host (
        .core_clk        (core_clk),
        .chip_select_n   (chip_select_n),
        .read_strobe_n   (read_strobe_n),
        .write_strobe_n  (write_strobe_n),
        .register_select (register_select),
        .host_data_in    (host_data_in),
        .host_data_out   (host_data_out),
        .host_data_oe    (host_data_oe),
        .ready           (ready)
    );

    // =========================================================
    // Helpers
    // =========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic put(input logic sel, input logic [7:0] d);
        i_host.access(sel, 1'b1, d, rdv, stv);
    endtask

    task automatic get(input logic sel);
        i_host.access(sel, 1'b0, 8'h00, rdv, stv);
    endtask

    // Bounded wait for end of execution
    task automatic wait_end();
        int n;
        n = 0;
        while (end_of_exec_n !== 1'b0 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        check({7'h0, end_of_exec_n}, 8'h00);
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // =========================================================
    // Test sequence
    // =========================================================
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(negedge core_clk);
        check({6'h0, service_request_out, end_of_exec_n}, 8'h01);
        check({7'h0, host_data_oe}, 8'h00);
        $display("test reset done");

        for (int i = 0; i < 12; i++) begin
            put(1'b1, cmds[i]);
            check(cmd_current, cmds[i]);
            check({5'h0, cmd_class}, {5'h0, cls[i]});
            check({7'h0, service_request_out}, 8'h00);
            wait_end();
            @(negedge core_clk);
            check({7'h0, service_request_out}, {7'h0, cmds[i][7]});
            if (i % 2 == 0) begin
                @(posedge core_clk);
                service_ack_in <= 1'b0;
                repeat (4) @(negedge core_clk);
                check({7'h0, service_request_out}, 8'h00);
                @(posedge core_clk);
                service_ack_in <= 1'b1;
            end
            @(posedge core_clk);
            end_ack_n <= 1'b0;
            repeat (4) @(negedge core_clk);
            check({7'h0, end_of_exec_n}, 8'h01);
            @(posedge core_clk);
            end_ack_n <= 1'b1;
        end
        $display("test opcodes done");

        put(1'b1, 8'h50);
        check({5'h0, cmd_class}, {5'h0, CL_UNDEF});
        wait_end();
        get(1'b1);
        check(rdv, 8'h01);
        check({7'h0, stv}, 8'h00);
        check({7'h0, end_of_exec_n}, 8'h01);
        $display("test illegal done");

        put(1'b1, 8'h02);
        get(1'b1);
        check({7'h0, stv}, 8'h01);
        check(rdv, 8'h00);
        put(1'b0, 8'ha5);
        put(1'b0, 8'h3c);
        get(1'b0);
        check(rdv, 8'h3c);
        get(1'b0);
        check(rdv, 8'ha5);
        check({7'h0, host_data_oe}, 8'h00);
        $display("test stall and stack done");

        put(1'b1, 8'h82);
        repeat (20) @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        check({6'h0, service_request_out, end_of_exec_n}, 8'h01);
        check(cmd_current, 8'h82);
        repeat (8) @(posedge core_clk);
        get(1'b1);
        check(rdv, 8'h00);
        check({7'h0, stv}, 8'h00);
        $display("test mid reset done");
        give_verdict();
    end
endmodule // test_math_unit_command_handshake
